// [core/ssr_defines.svh]
/*
 Status summary constants: bit positions, reset values and register selects.
 Assumes inclusion by bare name from the design files of the status summary block.
*/
// Function
// - Bit six summarises the other bits.
// - Query and serial poll return same byte.
// - Enable per bit; enable bit six ignored.
// - Enabled rising bit raises service request.
// - Enable mask written and read back.
// - Error queue entry sets bit two.
// - Each new error entry requests service when enable bit two is set.
// - Bit four follows message available.
// - Bit five is masked event OR.
// - Bit six set when enabled bit set.
// - Flag not in poll byte or query; the flag is only on o_ist, and no read select returns it.
// - Flag ORs the byte bits masked by poll mask.
// - Poll mask written and read back.
`ifndef SSR_DEFINES_SVH
`define SSR_DEFINES_SVH
// ---------------------------------------------------------------
// Bit positions and reset values
// ---------------------------------------------------------------
`define SSR_BIT_ERR   2
`define SSR_BIT_MSG   4
`define SSR_BIT_EVT   5
`define SSR_BIT_SUM   6
`define SSR_USED_MASK 8'h34
`define SSR_FREE_MASK 8'h8B
`define SSR_REQ_RST   8'h00
`define SSR_POLL_RST  8'h00
// ---------------------------------------------------------------
// Register selects
// ---------------------------------------------------------------
`define SSR_SEL_BYTE 2'h0
`define SSR_SEL_REQ  2'h1
`define SSR_SEL_POLL 2'h2
`define SSR_SEL_NONE 2'h3
`endif

// [core/ssr_pkg.sv]
/*
 Types of the status summary block.
 Assumes nothing of its surroundings.
*/
package ssr_pkg;
    // Write request from the command parser.
    typedef struct packed {
        logic       req_wr;
        logic       poll_wr;
        logic [7:0] data;
    } ssr_wr_t;
    // Read answer toward the parser.
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } ssr_rd_t;
endpackage : ssr_pkg

// [core/ssr_mask_reg.sv]
/*
 One eight-bit mask register loaded by a write strobe.
 Assumes a synchronous strobe on i_clk.
*/
`include "ssr_defines.svh"
module ssr_mask_reg
    import ssr_pkg::*;
#(
    parameter logic [7:0] RST = 8'h00
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wr,
    input  wire logic [7:0] i_data,
    output logic [7:0]      o_mask
);
    // Mask storage; software value kept until next write.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_mask <= RST;
        end else if (i_wr) begin
            o_mask <= i_data;
        end
    end
endmodule : ssr_mask_reg

// [core/ssr_top.sv]
/*
 Status byte, service request and individual status flag logic.
 Assumes lower event register, error queue and output buffer drive synchronous levels and pulses.
*/
`include "ssr_defines.svh"
module ssr_top
    import ssr_pkg::*;
#(
    parameter int EVW = 8
) (
    input  wire logic           i_clk,
    input  wire logic           i_rst,
    input  wire ssr_wr_t        i_wr,
    input  wire logic           i_rd,
    input  wire logic [1:0]     i_rd_sel,
    input  wire logic           i_err_push,
    input  wire logic           i_err_empty,
    input  wire logic           i_msg_avail,
    input  wire logic [EVW-1:0] i_esr,
    input  wire logic [EVW-1:0] i_ese,
    input  wire logic           i_srq_ack,
    output ssr_rd_t             o_rd,
    output logic [7:0]          o_poll_byte,
    output logic                o_ist,
    output logic                o_srq
);
    // ---------------------------------------------------------------
    // Masks
    // ---------------------------------------------------------------
    // Both masks share the write data byte; each has its own strobe, so a command with both strobes set loads both masks.
    logic [7:0] request_mask;
    logic [7:0] poll_mask;

    ssr_mask_reg #(
        .RST (`SSR_REQ_RST)
    ) u_request_mask (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_wr   (i_wr.req_wr),
        .i_data (i_wr.data),
        .o_mask (request_mask)
    );

    ssr_mask_reg #(
        .RST (`SSR_POLL_RST)
    ) u_poll_mask (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_wr   (i_wr.poll_wr),
        .i_data (i_wr.data),
        .o_mask (poll_mask)
    );

    // ---------------------------------------------------------------
    // Status byte
    // ---------------------------------------------------------------
    logic       err_bit;
    logic       next_err_bit;
    logic [7:0] byte_prev;

    // The event summary is a pure level, so it follows the lower registers without delay.
    wire logic event_bit = |(i_esr & i_ese);

    // Push wins over an empty queue so a new entry is never lost.
    assign next_err_bit = i_err_push ? 1'b1 : (i_err_empty ? 1'b0 : err_bit);

    // Error queue flag; the queue itself lives outside this block.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            err_bit <= 1'b0;
        end else begin
            err_bit <= next_err_bit;
        end
    end

    // Status bits without the summary; the positions without a function are tied low.
    wire logic [7:0] byte_low;
    assign byte_low = {1'b0, 1'b0, event_bit, i_msg_avail, 1'b0, err_bit, 2'b00};

    // Enable bit six is dropped here, so the summary can never feed itself.
    wire logic [7:0] req_eff = request_mask & `SSR_USED_MASK;
    wire logic       sum_bit = |(byte_low & req_eff);

    // Full status byte: the summary takes position six.
    wire logic [7:0] status_byte;
    assign status_byte = byte_low | ({7'h00, sum_bit} << `SSR_BIT_SUM);

    // The flag keeps bit six in its combination, unlike the service request.
    assign o_ist = |(status_byte & poll_mask);

    // ---------------------------------------------------------------
    // Service request
    // ---------------------------------------------------------------
    logic [7:0] rise;
    logic       next_srq;

    // Per-bit rise detector against the status bits of the previous cycle.
    for (genvar b = 0; b < 8; b++) begin : g_rise
        assign rise[b] = byte_low[b] & ~byte_prev[b];
    end

    // A fresh error push counts as a rise even while bit two stays set.
    wire logic trig = (|(rise & req_eff)) | (i_err_push & request_mask[`SSR_BIT_ERR]);

    // A trigger in the acknowledge cycle keeps the request up, so a late ack swallows no event.
    assign next_srq = trig ? 1'b1 : (i_srq_ack ? 1'b0 : o_srq);

    // Previous status bits and the sticky request flag.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            byte_prev <= 8'h00;
            o_srq     <= 1'b0;
        end else begin
            byte_prev <= byte_low;
            o_srq     <= next_srq;
        end
    end

    // ---------------------------------------------------------------
    // Read port and poll byte
    // ---------------------------------------------------------------
    // Select code three has no register behind it and reads as zero.
    logic [7:0] rd_mux;
    assign rd_mux = (i_rd_sel == `SSR_SEL_REQ)  ? request_mask :
                    (i_rd_sel == `SSR_SEL_POLL) ? poll_mask :
                    (i_rd_sel == `SSR_SEL_BYTE) ? status_byte : 8'h00;

    // Poll byte and query share one source so both views agree.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd        <= '0;
            o_poll_byte <= 8'h00;
        end else begin
            o_rd.valid  <= i_rd;
            o_rd.data   <= i_rd ? rd_mux : o_rd.data;
            o_poll_byte <= status_byte;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    // Steps of the request and readback behaviours.
    sequence s_push;
        i_err_push && request_mask[`SSR_BIT_ERR];
    endsequence

    sequence s_req_write;
        i_wr.req_wr;
    endsequence

    sequence s_req_read;
        i_rd && i_rd_sel == `SSR_SEL_REQ && !i_wr.req_wr;
    endsequence

    sequence s_poll_write;
        i_wr.poll_wr;
    endsequence

    sequence s_poll_read;
        i_rd && i_rd_sel == `SSR_SEL_POLL && !i_wr.poll_wr;
    endsequence

    chk_push_srq: assert property (@(posedge i_clk) disable iff (i_rst) s_push |=> o_srq)
        else $error("error push without request");

    chk_err_set: assert property (@(posedge i_clk) disable iff (i_rst) i_err_push |=> err_bit)
        else $error("error bit not set");

    chk_err_clr: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_err_push && i_err_empty) |=> !err_bit)
        else $error("error bit not cleared");

    chk_unused_zero: assert property (@(posedge i_clk) disable iff (i_rst)
        (status_byte & `SSR_FREE_MASK) == 8'h00)
        else $error("unused bit set");

    chk_sum_bit: assert property (@(posedge i_clk) disable iff (i_rst)
        status_byte[`SSR_BIT_SUM] == |(status_byte & request_mask & 8'hBF))
        else $error("summary bit wrong");

    // Built from the inputs bit by bit, so a slip in the byte assembly shows up here.
    chk_ist_or: assert property (@(posedge i_clk) disable iff (i_rst)
        o_ist == ((poll_mask[`SSR_BIT_SUM] & sum_bit) | (poll_mask[`SSR_BIT_EVT] & (|(i_esr & i_ese)))
                  | (poll_mask[`SSR_BIT_MSG] & i_msg_avail) | (poll_mask[`SSR_BIT_ERR] & err_bit)))
        else $error("status flag wrong");

    chk_rise_srq: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_msg_avail && !$past(i_msg_avail) && request_mask[`SSR_BIT_MSG] && !$past(i_rst)) |=> o_srq)
        else $error("rise without request");

    chk_srq_hold: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_srq && !i_srq_ack) |=> o_srq)
        else $error("request dropped without ack");

    chk_ack_clear: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_srq && i_srq_ack && !trig) |=> !o_srq)
        else $error("request kept after ack");

    chk_no_cause: assert property (@(posedge i_clk) disable iff (i_rst)
        (!o_srq && !trig) |=> !o_srq)
        else $error("request without cause");

    chk_msg_bit: assert property (@(posedge i_clk) disable iff (i_rst)
        status_byte[`SSR_BIT_MSG] == i_msg_avail)
        else $error("message bit wrong");

    chk_poll_same: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_rd && i_rd_sel == `SSR_SEL_BYTE) |=> o_rd.data == o_poll_byte)
        else $error("poll and query differ");

    chk_poll_lag: assert property (@(posedge i_clk) disable iff (i_rst)
        1'b1 |=> o_poll_byte == $past(status_byte))
        else $error("poll byte stale");

    chk_req_back: assert property (@(posedge i_clk) disable iff (i_rst)
        s_req_write ##1 s_req_read |=> o_rd.data == $past(i_wr.data, 2))
        else $error("request mask readback wrong");

    chk_poll_back: assert property (@(posedge i_clk) disable iff (i_rst)
        s_poll_write ##1 s_poll_read |=> o_rd.data == $past(i_wr.data, 2))
        else $error("poll mask readback wrong");

    chk_unused_read: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_rd && i_rd_sel == `SSR_SEL_NONE) |=> o_rd.data == 8'h00)
        else $error("unused select not zero");

    chk_rd_valid: assert property (@(posedge i_clk) disable iff (i_rst)
        i_rd |=> o_rd.valid)
        else $error("read without answer");

    chk_rd_idle: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rd |=> !o_rd.valid)
        else $error("answer without read");

    chk_event_sum: assert property (@(posedge i_clk) disable iff (i_rst)
        status_byte[`SSR_BIT_EVT] == |(i_esr & i_ese))
        else $error("event summary wrong");
endmodule : ssr_top

// [test/ssr_ctrl_model.sv]
/*
 Remote controller model: serial polls and acknowledges a service request.
 Assumes the block's o_srq and o_poll_byte on the same clock.
*/
module ssr_ctrl_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_en,
    input  wire logic       i_srq,
    input  wire logic [7:0] i_poll,
    output logic            o_ack,
    output logic [7:0]      o_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------
    // Poll on request
    // --------------------------------
    // One ack per request; while disabled the request is left pending, as a slow controller would.
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_ack  <= 1'b0;
            o_seen <= 8'h00;
        end else begin
            o_ack <= i_en && i_srq && !o_ack;
            if (i_en && i_srq && !o_ack) begin
                o_seen <= i_poll;
            end
        end
    end
endmodule : ssr_ctrl_model

// [test/ssr_top_tb.sv]
/*
 Self-checking bench of the status summary block.
 Assumes the controller model acknowledges requests only when enabled.
*/
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module ssr_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ssr_pkg::*;
    logic       i_clk = 0, i_rst = 1, i_rd = 0, i_err_push = 0, i_err_empty = 1, i_msg_avail = 0, en = 0;
    logic [1:0] i_rd_sel = 2'h0;
    logic [7:0] i_esr = 8'h00, i_ese = 8'h00, o_poll_byte, seen;
    logic       o_ist, o_srq, ack;
    ssr_wr_t    i_wr = '0;
    ssr_rd_t    o_rd;
    int         failures = 0, cmp_count = 0;
    always #5 i_clk = ~i_clk;
    ssr_top DUT (.i_clk, .i_rst, .i_wr, .i_rd, .i_rd_sel, .i_err_push, .i_err_empty, .i_msg_avail,
        .i_esr, .i_ese, .i_srq_ack(ack), .o_rd, .o_poll_byte, .o_ist, .o_srq);
    ssr_ctrl_model CTRL (.i_clk, .i_rst, .i_en(en), .i_srq(o_srq), .i_poll(o_poll_byte), .o_ack(ack),
        .o_seen(seen));
    // --------------------------------
    // Access tasks
    // --------------------------------
    task tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask : tick
    task wr(input logic s, input logic p, input logic [7:0] d);
        i_wr = '{s, p, d};
        tick(1);
        i_wr = '0;
    endtask : wr
    // Waits a bounded time for the answer, so a lost read shows as a mismatch.
    task rd(input logic [1:0] sel, input logic [7:0] exp);
        int k;
        i_rd = 1;
        i_rd_sel = sel;
        tick(1);
        i_rd = 0;
        for (k = 0; k < 3 && o_rd.valid !== 1'b1; k++) tick(1);
        `CHK(o_rd.valid, 1'b1)
        `CHK(o_rd.data, exp)
        tick(1);
    endtask : rd
    task pulse_ack;
        en = 1;
        tick(3);
        en = 0;
    endtask : pulse_ack
    task finish_test;
        if (failures == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    // --------------------------------
    // Scenarios
    // --------------------------------
    initial begin
        tick(3);
        i_rst = 0;
        `CHK(o_srq, 1'b0)
        rd(0, 8'h00);
        rd(1, 8'h00);
        rd(2, 8'h00);
        wr(1, 0, 8'h10);
        rd(1, 8'h10);
        wr(0, 1, 8'h40);
        rd(2, 8'h40);
        rd(3, 8'h00);
        i_msg_avail = 1;
        tick(3);
        `CHK(o_srq, 1'b1)
        rd(0, 8'h50);
        `CHK(o_poll_byte, 8'h50)
        `CHK(o_ist, 1'b1)
        pulse_ack();
        `CHK(o_srq, 1'b0)
        `CHK(seen, 8'h50)
        wr(1, 0, 8'h40);
        tick(2);
        rd(0, 8'h10);
        `CHK(o_ist, 1'b0)
        i_msg_avail = 0;
        wr(1, 0, 8'h04);
        i_err_empty = 0;
        i_err_push = 1;
        tick(1);
        i_err_push = 0;
        tick(2);
        `CHK(o_srq, 1'b1)
        rd(0, 8'h44);
        pulse_ack();
        `CHK(o_srq, 1'b0)
        i_err_push = 1;
        tick(1);
        i_err_push = 0;
        tick(2);
        `CHK(o_srq, 1'b1)
        i_err_empty = 1;
        pulse_ack();
        `CHK(o_srq, 1'b0)
        rd(0, 8'h00);
        wr(1, 1, 8'h20);
        i_esr = 8'h81;
        i_ese = 8'h80;
        tick(3);
        `CHK(o_srq, 1'b1)
        rd(0, 8'h60);
        `CHK(o_ist, 1'b1)
        i_ese = 8'h02;
        tick(2);
        rd(0, 8'h00);
        finish_test();
    end
    // The whole sequence takes well under 200 cycles.
    initial begin
        #20000;
        failures++;
        finish_test();
    end
endmodule : ssr_top_tb
